// [baud_gen.sv]
// Purpose: transfer clock of one channel, prescaler then counter
// Assumes: clr held while the channel is idle
// Notes:   one tick per half bit; psel 0 and div 0 tick every cycle
`timescale 1ns/1ps
module baud_gen
#(
  parameter int PW = serial_unit_pkg::PSEL_W,
  parameter int DW = serial_unit_pkg::DIV_W
)
(
  input  logic          clk,
  input  logic          sys_rst,
  input  logic          clr,
  input  logic [PW-1:0] psel,
  input  logic [DW-1:0] div,
  output logic          tick_reg
);

  logic [15:0]   pre_reg;
  logic [DW-1:0] cnt_reg;
  logic          pp;

  // =============================================================
  // prescaler and channel counter
  assign pp = &(pre_reg | (serial_unit_pkg::PRE_ALL << psel));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_reg  <= '0;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (clr)
    begin
      pre_reg  <= '0;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      pre_reg  <= pre_reg + 16'h0001;
      tick_reg <= pp & (cnt_reg == div);
      if (pp)
        cnt_reg <= (cnt_reg == div) ? '0 : DW'(cnt_reg + 1'b1);
    end
  end

  // =============================================================
  // checks
  property p_tick_gap;
    @(posedge clk) disable iff (sys_rst)
    tick_reg && (div != '0) |=> !tick_reg;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeated too soon");

  property p_clr_quiet;
    @(posedge clk) disable iff (sys_rst)
    clr |=> !tick_reg;
  endproperty
  a_clr_quiet: assert property (p_clr_quiet) else $error("tick while cleared");

endmodule : baud_gen

// [serial_channel.sv]
// Purpose: one serial channel: clocked, select-slave, uart, two-wire
// Assumes: pins synchronous to clk; software steers via cfg ports
// Notes:   a unit holds four instances, the device two units
`timescale 1ns/1ps
module serial_channel
#(
  parameter int CH_IDX = 0
)
(
  input  logic                   clk,
  input  logic                   sys_rst,
  input  serial_unit_pkg::cfg_t  cfg,
  input  logic                   tx_wr,
  input  logic [8:0]             tx_data,
  input  logic                   rx_rd,
  input  logic                   err_clr,
  input  logic                   sw_scl,
  input  logic                   sw_sda,
  input  logic                   sck_in,
  input  logic                   ss_n_in,
  input  logic                   sdi,
  output logic                   sck_out_reg,
  output logic                   sck_oe_reg,
  output logic                   sdo_reg,
  output logic                   sdo_oe_reg,
  output logic [8:0]             rx_data_reg,
  output serial_unit_pkg::stat_t stat_reg,
  output logic                   end_irq_reg,
  output logic                   empty_irq_reg,
  output logic                   err_irq_reg,
  output logic                   rxd_lvl_reg,
  output logic                   lin_fall_reg
);

  localparam bit TX_CH = (CH_IDX % 2) == 0;

  serial_unit_pkg::st_t st_reg;
  logic        ph_reg;
  logic        first_reg;
  logic        lead_reg;
  logic [3:0]  bcnt_reg;
  logic [11:0] sh_reg;
  logic [11:0] rsh_reg;
  logic [8:0]  tx_buf_reg;
  logic [3:0]  dl;
  logic [3:0]  dn;
  logic [3:0]  nb;
  logic [8:0]  dmask;
  logic [8:0]  dord;
  logic [8:0]  dsel;
  logic [8:0]  rxv;
  logic [11:0] fr;
  logic [11:0] ld;
  logic [11:0] rsh_nx;
  logic [11:0] raw;
  logic        is_uart;
  logic        is_iic;
  logic        is_ss;
  logic        slave;
  logic        run;
  logic        tick;
  logic        sb;
  logic        lead;
  logic        ea;
  logic        eb;
  logic        ln;
  logic        smp;
  logic        ss_ok;
  logic        start;
  logic        take;
  logic        acc;
  logic        done;
  logic        abort;
  logic        rx_ok;
  logic        ovr_set;
  logic        fe_set;
  logic        pe_set;
  logic        ack_set;
  logic        sck_v;
  logic        sck_oe_v;
  logic        sdo_v;
  logic        sdo_oe_v;

  // =============================================================
  // helpers
  function automatic logic [8:0] order(input logic [8:0] v, input logic [3:0] n, input logic msb);
    logic [8:0] r;
    r = v;
    if (msb)
    begin
      for (int i = 0; i < 9; i++)
        if (i < int'(n))
          r[i] = v[4'(int'(n) - 1 - i)];
    end
    return r;
  endfunction : order

  // =============================================================
  // decode
  assign is_uart = cfg.mode == serial_unit_pkg::MODE_UART;
  assign is_iic  = cfg.mode == serial_unit_pkg::MODE_IIC;
  assign is_ss   = cfg.mode == serial_unit_pkg::MODE_CSI_SS;
  assign slave   = is_ss | (cfg.mode == serial_unit_pkg::MODE_CSI & ~cfg.master);
  assign ss_ok   = ~is_ss | ~ss_n_in;
  assign run     = st_reg == serial_unit_pkg::ST_RUN;
  assign sb      = sdi ^ (cfg.inv_rx & ~is_iic);

  always_comb
  begin
    unique case (cfg.len)
      serial_unit_pkg::LEN_7: dl = serial_unit_pkg::BITS_7;
      serial_unit_pkg::LEN_9: dl = is_uart ? serial_unit_pkg::BITS_9 : serial_unit_pkg::BITS_8;
      default:                dl = serial_unit_pkg::BITS_8;
    endcase
  end

  // two-wire bytes are fixed at eight bits, msb first, address in the top seven
  assign dn    = is_iic ? serial_unit_pkg::BITS_8 : dl;
  assign dmask = serial_unit_pkg::MASK_9 >> (serial_unit_pkg::BITS_9 - dn);
  assign dord  = order(tx_buf_reg, dn, cfg.msb_first | is_iic);
  assign nb    = is_iic ? serial_unit_pkg::BITS_IIC
               : is_uart ? 4'(dl + 4'h2 + {3'h0, cfg.par_en}) : dl;

  // =============================================================
  // transmit frame and load value
  always_comb
  begin
    fr    = '1;
    fr[0] = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < int'(dl))
        fr[i + 1] = dord[i];
    if (cfg.par_en)
      fr[4'(dl + 4'h1)] = ^(dord & dmask) ^ cfg.par_odd;
  end

  always_comb
  begin
    if (is_uart)
      ld = fr;
    else if (is_iic)
      ld = cfg.iic_rcv ? {3'h7, ~cfg.ack_en, 8'hFF} : {4'hF, dord[7:0]};
    else
      ld = stat_reg.tx_full ? {3'h7, dord} : '1;
  end

  // =============================================================
  // events
  assign lead = sck_in ^ cfg.ck_pol;
  // slave edges come from a sampled pin, hence the six-clock minimum period
  assign ea   = slave ? (lead & ~lead_reg) : (tick & ~ph_reg);
  assign eb   = slave ? (~lead & lead_reg) : (tick & ph_reg);
  assign ln   = cfg.dat_phase ? ea : eb;
  assign smp  = run & ((is_uart | is_iic) ? (tick & ~ph_reg) : (cfg.dat_phase ? eb : ea));

  assign rsh_nx = smp ? {sb, rsh_reg[11:1]} : rsh_reg;
  assign raw    = rsh_nx >> (serial_unit_pkg::BITS_FRM - nb);
  assign dsel   = is_uart ? raw[9:1] : raw[8:0];
  assign rxv    = order(dsel & dmask, dn, cfg.msb_first | is_iic) & dmask;

  always_comb
  begin
    unique case (cfg.mode)
      serial_unit_pkg::MODE_UART:
        start = ~run & (TX_CH ? stat_reg.tx_full : (rxd_lvl_reg & ~sb));
      serial_unit_pkg::MODE_IIC:
        start = ~run & stat_reg.tx_full;
      default:
        start = ~run & (slave ? ss_ok : stat_reg.tx_full);
    endcase
    start = start & cfg.en;
  end

  always_comb
  begin
    unique case (cfg.mode)
      serial_unit_pkg::MODE_UART:
        done = run & tick & (TX_CH ? ph_reg : ~ph_reg) & (bcnt_reg == 4'(nb - 4'h1));
      serial_unit_pkg::MODE_IIC:
        done = run & tick & ph_reg & (bcnt_reg == serial_unit_pkg::BITS_IIC);
      default:
        done = run & eb & (4'(bcnt_reg + {3'h0, cfg.dat_phase}) == dl);
    endcase
  end

  // false start bit or dropped select ends the frame without a result
  assign abort = run & ((slave & ~ss_ok)
               | (is_uart & ~TX_CH & smp & (bcnt_reg == 4'h0) & sb) | ~cfg.en);
  assign take  = start & stat_reg.tx_full & ~(is_uart & ~TX_CH);
  assign acc   = tx_wr & (~stat_reg.tx_full | take);
  assign rx_ok = done & ~(is_uart & TX_CH) & ~(is_iic & ~cfg.iic_rcv);

  baud_gen u_brg
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (~run),
    .psel     (cfg.psel),
    .div      (cfg.div),
    .tick_reg (tick)
  );

  // =============================================================
  // shift engine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg    <= serial_unit_pkg::ST_IDLE;
      ph_reg    <= 1'b0;
      first_reg <= 1'b0;
      bcnt_reg  <= '0;
      sh_reg    <= '1;
      rsh_reg   <= '0;
      lead_reg  <= 1'b0;
    end
    else
    begin
      lead_reg <= lead;
      rsh_reg  <= rsh_nx;
      if (start)
      begin
        st_reg    <= serial_unit_pkg::ST_RUN;
        ph_reg    <= 1'b0;
        first_reg <= 1'b1;
        bcnt_reg  <= '0;
        sh_reg    <= ld;
      end
      else if (done | abort)
        st_reg <= serial_unit_pkg::ST_IDLE;
      else if (run & (is_uart | is_iic))
      begin
        if (tick)
        begin
          ph_reg <= ~ph_reg;
          if ((is_uart & TX_CH) ? ph_reg : ~ph_reg)
            bcnt_reg <= bcnt_reg + 4'h1;
          if (ph_reg)
            sh_reg <= {1'b1, sh_reg[11:1]};
        end
      end
      else if (run)
      begin
        if (tick & ~slave)
          ph_reg <= ~ph_reg;
        if (ln)
        begin
          first_reg <= 1'b0;
          if (~(first_reg & cfg.dat_phase))
            sh_reg <= {1'b1, sh_reg[11:1]};
        end
        if (smp)
          bcnt_reg <= bcnt_reg + 4'h1;
      end
    end
  end

  // =============================================================
  // line drivers
  always_comb
  begin
    sck_v    = cfg.ck_pol;
    sck_oe_v = 1'b0;
    sdo_v    = 1'b1;
    sdo_oe_v = 1'b0;
    unique case (cfg.mode)
      serial_unit_pkg::MODE_CSI, serial_unit_pkg::MODE_CSI_SS:
      begin
        sck_v    = cfg.ck_pol ^ (run & ph_reg);
        sck_oe_v = cfg.en & ~slave;
        sdo_v    = sh_reg[0] ^ cfg.inv_tx;
        sdo_oe_v = cfg.en & ss_ok;
      end
      serial_unit_pkg::MODE_UART:
      begin
        sdo_v    = (~run | sh_reg[0]) ^ cfg.inv_tx;
        sdo_oe_v = cfg.en & TX_CH;
      end
      serial_unit_pkg::MODE_IIC:
      begin
        // open drain: only ever pulls low; no clock readback, so no stretching
        sck_v    = 1'b0;
        sck_oe_v = cfg.en & ~(run ? ph_reg : sw_scl);
        sdo_v    = 1'b0;
        sdo_oe_v = cfg.en & ~(run ? sh_reg[0] : sw_sda);
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_out_reg  <= 1'b0;
      sck_oe_reg   <= 1'b0;
      sdo_reg      <= 1'b1;
      sdo_oe_reg   <= 1'b0;
      rxd_lvl_reg  <= 1'b1;
      lin_fall_reg <= 1'b0;
    end
    else
    begin
      sck_out_reg  <= sck_v;
      sck_oe_reg   <= sck_oe_v;
      sdo_reg      <= sdo_v;
      sdo_oe_reg   <= sdo_oe_v;
      rxd_lvl_reg  <= sb;
      lin_fall_reg <= rxd_lvl_reg & ~sb & is_uart & ~TX_CH;
    end
  end

  // =============================================================
  // buffers, flags and interrupts
  assign ovr_set = rx_ok & stat_reg.rx_full & ~rx_rd;
  assign fe_set  = done & is_uart & ~TX_CH & ~sb;
  assign pe_set  = done & is_uart & ~TX_CH & cfg.par_en
                 & (^(raw[9:1] & dmask) ^ cfg.par_odd ^ raw[4'(dl + 4'h1)]);
  assign ack_set = done & is_iic & ~cfg.iic_rcv & raw[8];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_reg      <= '0;
      tx_buf_reg    <= '0;
      rx_data_reg   <= '0;
      end_irq_reg   <= 1'b0;
      empty_irq_reg <= 1'b0;
      err_irq_reg   <= 1'b0;
    end
    else
    begin
      if (acc)
        tx_buf_reg <= tx_data;
      if (rx_ok)
        rx_data_reg <= rxv;
      // each flag: a set in the clear cycle wins
      stat_reg.tx_full <= acc | (stat_reg.tx_full & ~take);
      stat_reg.rx_full <= rx_ok | (stat_reg.rx_full & ~rx_rd);
      stat_reg.busy    <= start | (run & ~done & ~abort);
      stat_reg.ovr     <= ovr_set | (stat_reg.ovr & ~err_clr);
      stat_reg.fe      <= fe_set | (stat_reg.fe & ~err_clr);
      stat_reg.pe      <= pe_set | (stat_reg.pe & ~err_clr);
      stat_reg.ack_err <= ack_set | (stat_reg.ack_err & ~err_clr);
      end_irq_reg      <= done;
      empty_irq_reg    <= take;
      err_irq_reg      <= ovr_set | fe_set | pe_set | ack_set;
    end
  end

  // =============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_end;
    done |=> s_pulse(end_irq_reg);
  endproperty
  a_end: assert property (p_end) else $error("end pulse missing");

  property p_empty;
    take && !tx_wr |=> empty_irq_reg && !stat_reg.tx_full;
  endproperty
  a_empty: assert property (p_empty) else $error("buffer empty not shown");

  property p_ovr;
    ovr_set |=> stat_reg.ovr && err_irq_reg;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_fe;
    fe_set |=> stat_reg.fe && err_irq_reg && !stat_reg.busy;
  endproperty
  a_fe: assert property (p_fe) else $error("framing error not flagged");

  property p_ack;
    ack_set |=> stat_reg.ack_err ##1 stat_reg.ack_err || $past(err_clr);
  endproperty
  a_ack: assert property (p_ack) else $error("ack error lost");

  property p_ss;
    is_ss && ss_n_in |=> !sdo_oe_reg;
  endproperty
  a_ss: assert property (p_ss) else $error("drives data while deselected");

  property p_iic_od;
    is_iic |=> !sdo_reg && !sck_out_reg;
  endproperty
  a_iic_od: assert property (p_iic_od) else $error("two-wire line driven high");

  property p_rx_ch;
    is_uart && !TX_CH |=> !sdo_oe_reg;
  endproperty
  a_rx_ch: assert property (p_rx_ch) else $error("receive channel drives");

  property p_ck_idle;
    cfg.mode == serial_unit_pkg::MODE_CSI && cfg.master && !run |=> sck_out_reg == $past(cfg.ck_pol);
  endproperty
  a_ck_idle: assert property (p_ck_idle) else $error("idle clock level wrong");

endmodule : serial_channel

// [serial_partner.sv]
// Purpose: remote uart node facing the transmit and receive channels
// Assumes: both ends use the same bit time of BIT_CYC clocks
// Notes:   samples on the falling clock edge to stay clear of launch
`timescale 1ns/1ps
// ============================================================
// remote node
module serial_partner
#(
  parameter int BIT_CYC = 8
)
(
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // start found on the low level, then one sample per bit at its middle
  task automatic recv_frame(input int len, output logic [11:0] bits);
    int i;
    bits = 12'h000;
    @(negedge clk);
    while (line_in !== 1'b0)
      @(negedge clk);
    repeat (BIT_CYC / 2) @(negedge clk);
    for (i = 0; i < len; i++)
    begin
      bits[i] = line_in;
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask : recv_frame

  // bits leave in vector order; line is driven high again after stop
  task automatic send_frame(input logic [11:0] bits, input int len);
    int i;
    for (i = 0; i < len; i++)
    begin
      @(posedge clk);
      line_out <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask : send_frame
endmodule : serial_partner

// [serial_unit_pkg.sv]
// Purpose: shared types and constants of the serial channel
// Assumes: one channel per instance, four per unit, two units
// Notes:   sizes of fields fixed here, used by both design files
// =============================================================
// package
package serial_unit_pkg;

  localparam int NUM_UNITS    = 2;
  localparam int CH_PER_UNIT  = 4;
  localparam int PSEL_W       = 4;
  localparam int DIV_W        = 7;
  localparam int FRAME_W      = 12;

  localparam logic [3:0] BITS_7   = 4'h7;
  localparam logic [3:0] BITS_8   = 4'h8;
  localparam logic [3:0] BITS_9   = 4'h9;
  localparam logic [3:0] BITS_IIC = 4'h9;
  localparam logic [3:0] BITS_FRM = 4'hC;
  localparam logic [8:0] MASK_9   = 9'h1FF;
  localparam logic [15:0] PRE_ALL = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_CSI    = 2'b00,
    MODE_CSI_SS = 2'b01,
    MODE_UART   = 2'b10,
    MODE_IIC    = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    LEN_7 = 2'b00,
    LEN_8 = 2'b01,
    LEN_9 = 2'b10
  } len_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } st_t;

  typedef struct packed {
    logic              en;
    mode_t             mode;
    logic              master;
    len_t              len;
    logic              msb_first;
    logic              ck_pol;
    logic              dat_phase;
    logic              par_en;
    logic              par_odd;
    logic              inv_tx;
    logic              inv_rx;
    logic              iic_rcv;
    logic              ack_en;
    logic [PSEL_W-1:0] psel;
    logic [DIV_W-1:0]  div;
  } cfg_t;

  typedef struct packed {
    logic rx_full;
    logic tx_full;
    logic busy;
    logic ovr;
    logic fe;
    logic pe;
    logic ack_err;
  } stat_t;

endpackage : serial_unit_pkg

// [tb_top.sv]
// Purpose: uart transmit and receive channels against a remote node
// Assumes: psel 1, div 1 give a tick every 4 clocks, bit time 8 clocks
// Notes:   clocked master is looped back on itself; two-wire covers idle line control only
`timescale 1ns/1ps
// ============================================================
// bench
module tb_top;
  localparam int BIT_CYC = 8;
  logic                   clk;
  logic                   sys_rst;
  serial_unit_pkg::cfg_t  cfg_tx;
  serial_unit_pkg::cfg_t  cfg_rx;
  logic                   tx_wr;
  logic [8:0]             tx_data;
  logic                   rx_rd;
  logic                   err_clr;
  logic                   txd;
  logic                   rxd;
  logic                   tx_end;
  logic                   tx_empty;
  logic                   rx_err;
  logic [8:0]             rx_data;
  serial_unit_pkg::stat_t rx_stat;
  int                     num_errors;
  int                     tests_run;
  int                     n_end;
  int                     n_empty;
  int                     n_err;
  int                     n_fall;
  int                     n_sck;
  logic                   sck_d;
  logic                   sw_scl;
  logic                   sw_sda;
  logic                   sck_in;
  logic                   ss_n_in;
  logic                   sck;
  logic                   sck_oe;
  logic                   txd_oe;
  logic                   rx_fall;
  logic [8:0]             loop_data;

  // even channel reads its own data out back in, so clocked mode checks itself
  serial_channel #(.CH_IDX(0)) uut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg_tx), .tx_wr(tx_wr),
    .tx_data(tx_data), .rx_rd(rx_rd), .err_clr(err_clr), .sw_scl(sw_scl), .sw_sda(sw_sda), .sck_in(sck_in),
    .ss_n_in(ss_n_in), .sdi(txd), .sck_out_reg(sck), .sck_oe_reg(sck_oe), .sdo_reg(txd), .sdo_oe_reg(txd_oe),
    .rx_data_reg(loop_data), .stat_reg(), .end_irq_reg(tx_end), .empty_irq_reg(tx_empty), .err_irq_reg(),
    .rxd_lvl_reg(), .lin_fall_reg());
  serial_channel #(.CH_IDX(1)) uut_odd (.clk(clk), .sys_rst(sys_rst), .cfg(cfg_rx), .tx_wr(1'b0),
    .tx_data(9'h000), .rx_rd(rx_rd), .err_clr(err_clr), .sw_scl(sw_scl), .sw_sda(sw_sda), .sck_in(sck_in),
    .ss_n_in(ss_n_in), .sdi(rxd), .sck_out_reg(), .sck_oe_reg(), .sdo_reg(), .sdo_oe_reg(),
    .rx_data_reg(rx_data), .stat_reg(rx_stat), .end_irq_reg(), .empty_irq_reg(),
    .err_irq_reg(rx_err), .rxd_lvl_reg(), .lin_fall_reg(rx_fall));
  serial_partner #(.BIT_CYC(BIT_CYC)) partner (.clk(clk), .line_in(txd), .line_out(rxd));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses counted so each scenario can compare a before/after snapshot
  always @(posedge clk)
  begin
    if (tx_end === 1'b1) n_end++;
    if (tx_empty === 1'b1) n_empty++;
    if (rx_err === 1'b1) n_err++;
    if (rx_fall === 1'b1) n_fall++;
    if (sck === 1'b1 && sck_d === 1'b0) n_sck++;
    sck_d <= sck;
  end

  // ============================================================
  // helpers
  task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_val(name, {11'h000, exp}, {11'h000, got});
  endtask : check_bit

  // expected line bits: start, data in chosen order, optional parity, stop
  function automatic logic [11:0] mk_frame(input logic [8:0] d, input int n, input logic msb,
                                           input logic pe, input logic po);
    logic [11:0] f;
    logic        p;
    f = 12'h000;
    p = po;
    for (int i = 0; i < n; i++)
    begin
      f[1 + i] = msb ? d[n - 1 - i] : d[i];
      p = p ^ d[i];
    end
    f[1 + n] = pe ? p : 1'b1;
    f[2 + n] = 1'b1;
    return f;
  endfunction : mk_frame

  task automatic set_uart(input serial_unit_pkg::len_t l, input logic msb, input logic pe,
                          input logic po, input logic inv);
    serial_unit_pkg::cfg_t c;
    c = '0;
    c.en = 1'b1;
    c.mode = serial_unit_pkg::MODE_UART;
    c.master = 1'b1;
    c.len = l;
    c.msb_first = msb;
    c.par_en = pe;
    c.par_odd = po;
    c.psel = 4'h1;
    c.div = 7'h01;
    @(posedge clk);
    cfg_rx <= c;
    c.inv_tx = inv;
    cfg_tx <= c;
    repeat (3) @(posedge clk);
  endtask : set_uart

  task automatic pulse_rd_clr();
    @(posedge clk);
    rx_rd <= 1'b1;
    err_clr <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
    err_clr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse_rd_clr

  task automatic tx_frame(input logic [8:0] d, input int n, input logic msb, input logic pe, input logic po);
    logic [11:0] got;
    int          e0;
    int          m0;
    e0 = n_end;
    m0 = n_empty;
    fork
      begin
        @(posedge clk);
        tx_data <= d;
        tx_wr <= 1'b1;
        @(posedge clk);
        tx_wr <= 1'b0;
      end
      partner.recv_frame(n + 3, got);
    join
    check_val("uart tx frame", mk_frame(d, n, msb, pe, po) & ~(12'hFFF << (n + 3)), got);
    check_val("end pulses", 12'h001, 12'(n_end - e0));
    check_val("empty pulses", 12'h001, 12'(n_empty - m0));
  endtask : tx_frame

  // ============================================================
  // scenarios
  task automatic t_tx_8_lsb();
    set_uart(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 1'b0);
    tx_frame(9'h0B1, 8, 1'b0, 1'b0, 1'b0);
  endtask : t_tx_8_lsb

  task automatic t_tx_7_msb_parity();
    set_uart(serial_unit_pkg::LEN_7, 1'b1, 1'b1, 1'b0, 1'b0);
    tx_frame(9'h04D, 7, 1'b1, 1'b1, 1'b0);
    set_uart(serial_unit_pkg::LEN_9, 1'b0, 1'b1, 1'b1, 1'b0);
    tx_frame(9'h1C3, 9, 1'b0, 1'b1, 1'b1);
  endtask : t_tx_7_msb_parity

  task automatic t_tx_inverted_idle();
    set_uart(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    check_bit("inverted idle level", 1'b0, txd);
    check_bit("transmit drive enable", 1'b1, txd_oe);
    set_uart(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 1'b0);
    @(negedge clk);
    check_bit("plain idle level", 1'b1, txd);
  endtask : t_tx_inverted_idle

  task automatic t_rx_9_bit();
    int f0;
    set_uart(serial_unit_pkg::LEN_9, 1'b0, 1'b0, 1'b0, 1'b0);
    f0 = n_fall;
    partner.send_frame(mk_frame(9'h1A5, 9, 1'b0, 1'b0, 1'b0), 11);
    check_val("rx nine bit data", 12'h1A5, {3'h0, rx_data});
    check_val("rx falling edges", 12'h004, 12'(n_fall - f0));
    check_bit("rx full", 1'b1, rx_stat.rx_full);
    pulse_rd_clr();
    check_bit("rx full after read", 1'b0, rx_stat.rx_full);
  endtask : t_rx_9_bit

  task automatic t_rx_parity_error();
    logic [11:0] f;
    int          e0;
    set_uart(serial_unit_pkg::LEN_8, 1'b1, 1'b1, 1'b0, 1'b0);
    f = mk_frame(9'h03C, 8, 1'b1, 1'b1, 1'b0);
    f[9] = ~f[9];
    e0 = n_err;
    partner.send_frame(f, 11);
    check_bit("parity flag", 1'b1, rx_stat.pe);
    check_val("error pulses", 12'h001, 12'(n_err - e0));
    pulse_rd_clr();
    check_bit("parity flag cleared", 1'b0, rx_stat.pe);
  endtask : t_rx_parity_error

  task automatic t_rx_frame_error();
    logic [11:0] f;
    set_uart(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 1'b0);
    f = mk_frame(9'h081, 8, 1'b0, 1'b0, 1'b0);
    f[9] = 1'b0;
    partner.send_frame(f, 10);
    check_bit("framing flag", 1'b1, rx_stat.fe);
    check_bit("no parity flag", 1'b0, rx_stat.pe);
    pulse_rd_clr();
  endtask : t_rx_frame_error

  task automatic t_rx_overrun();
    set_uart(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 1'b0);
    partner.send_frame(mk_frame(9'h055, 8, 1'b0, 1'b0, 1'b0), 10);
    check_bit("no overrun yet", 1'b0, rx_stat.ovr);
    partner.send_frame(mk_frame(9'h0AA, 8, 1'b0, 1'b0, 1'b0), 10);
    check_bit("overrun flag", 1'b1, rx_stat.ovr);
    check_val("newest data kept", 12'h0AA, {3'h0, rx_data});
    pulse_rd_clr();
    check_bit("overrun cleared", 1'b0, rx_stat.ovr);
  endtask : t_rx_overrun

  // clocked master at a tick every 4 clocks; the loop needs launch to settle before the next sample
  task automatic csi_frame(input serial_unit_pkg::len_t l, input logic msb, input logic pol, input logic ph,
                           input logic [8:0] d, input int n);
    serial_unit_pkg::cfg_t c;
    int                    e0;
    int                    k0;
    c = '0;
    c.en = 1'b1;
    c.master = 1'b1;
    c.len = l;
    c.msb_first = msb;
    c.ck_pol = pol;
    c.dat_phase = ph;
    c.psel = 4'h1;
    c.div = 7'h01;
    @(posedge clk);
    cfg_tx <= c;
    repeat (3) @(posedge clk);
    e0 = n_end;
    k0 = n_sck;
    tx_data <= d;
    tx_wr <= 1'b1;
    @(posedge clk);
    tx_wr <= 1'b0;
    repeat (90) @(posedge clk);
    check_val("clocked loopback data", {3'h0, d}, {3'h0, loop_data});
    check_val("clock pulses", 12'(n), 12'(n_sck - k0));
    check_val("clocked end pulses", 12'h001, 12'(n_end - e0));
    check_bit("clock idle level", pol, sck);
    check_bit("clock drive enable", 1'b1, sck_oe);
  endtask : csi_frame

  task automatic t_csi_master();
    csi_frame(serial_unit_pkg::LEN_8, 1'b0, 1'b0, 1'b0, 9'h0B4, 8);
    csi_frame(serial_unit_pkg::LEN_7, 1'b1, 1'b1, 1'b1, 9'h05A, 7);
  endtask : t_csi_master

  // start and stop made by software through the idle line levels
  task automatic t_iic_start_stop();
    serial_unit_pkg::cfg_t c;
    c = '0;
    c.en = 1'b1;
    c.mode = serial_unit_pkg::MODE_IIC;
    c.master = 1'b1;
    @(posedge clk);
    cfg_tx <= c;
    sw_sda <= 1'b0;
    repeat (2) @(posedge clk);
    sw_scl <= 1'b0;
    @(negedge clk);
    check_bit("start data pulled", 1'b1, txd_oe);
    check_bit("start clock still free", 1'b0, sck_oe);
    @(negedge clk);
    check_bit("start clock pulled", 1'b1, sck_oe);
    @(posedge clk);
    sw_scl <= 1'b1;
    sw_sda <= 1'b1;
    repeat (2) @(negedge clk);
    check_bit("stop lines released", 1'b0, sck_oe | txd_oe);
  endtask : t_iic_start_stop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // ============================================================
  // main sequence and watchdog
  initial
  begin
    sys_rst = 1'b1;
    cfg_tx = '0;
    cfg_rx = '0;
    tx_wr = 1'b0;
    tx_data = 9'h000;
    rx_rd = 1'b0;
    err_clr = 1'b0;
    num_errors = 0;
    tests_run = 0;
    n_end = 0;
    n_empty = 0;
    n_err = 0;
    n_fall = 0;
    n_sck = 0;
    sw_scl = 1'b1;
    sw_sda = 1'b1;
    sck_in = 1'b0;
    ss_n_in = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_tx_8_lsb();
    t_tx_7_msb_parity();
    t_tx_inverted_idle();
    t_rx_9_bit();
    t_rx_parity_error();
    t_rx_frame_error();
    t_rx_overrun();
    t_csi_master();
    t_iic_start_stop();
    end_of_test();
  end

  // whole run is about 1000 clocks; allow far more before calling it hung
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
